//--- core/flash_power_gate.sv
/*
 Power-on state and command admission for a serial flash.
 Assumes: supply level indicators arrive as asynchronous pins, the host
 clocks opcodes in on i_sck (rising edge, MSB first) while i_cs_n is low,
 and i_sck stands still while i_cs_n is high.
 Every eighth link edge in a frame completes one opcode, so frames are expected
 to carry opcodes only; longer frames are classified byte by byte.
*/
`timescale 1ns/1ns

// What this block does
// - After power-up the device sits in ordinary standby, never deep power-down unless told so.
// - The write-enable latch is cleared during power-up and needs a fresh write-enable command.
// - Below the lockout threshold the core logic is held in reset (the link capture keeps running) and every command is ignored.
// - Write-class commands are refused until the write-access delay after lockout has run out.
// - Read commands are accepted once the supply-settle delay has run, even if writes still wait.
module flash_power_gate
	import flash_power_pkg::*;
#(
	parameter int WRITE_ACCESS_CYCLES = WRITE_ACCESS_CYCLES_DEF,
	parameter int SUPPLY_SETTLE_CYCLES = SUPPLY_SETTLE_CYCLES_DEF,
	parameter int CNT_W = DELAY_CNT_W_DEF
)
(
	// System
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Supply monitors (asynchronous)
	input wire logic i_above_lockout,
	input wire logic i_supply_at_min,
	// Link from host
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	// Status and admitted commands
	output logic o_standby,
	output logic o_deep_power_down,
	output logic o_write_enable_latch,
	output logic o_read_ready,
	output logic o_write_ready,
	output logic o_cmd_valid,
	output logic o_cmd_refused,
	output logic [7:0] o_cmd_opcode,
	output power_state_e o_power_state
);

	// ----------------------------------------------------------------
	// Link domain: opcode capture
	// ----------------------------------------------------------------
	logic [6:0] shift;
	logic [2:0] bit_cnt;
	logic [7:0] opcode_hold;
	logic cmd_toggle;
	wire byte_done = (bit_cnt == 3'h7);

	// Chip select high restarts the byte; the clock may stop between frames
	always_ff @(posedge i_sck or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			shift <= 7'h00;
			bit_cnt <= 3'h0;
		end
		else
		begin
			shift <= {shift[5:0], i_mosi};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// Held word stays stable for at least 8 link clocks, long enough to cross
	// The core reads it only after the toggle has passed its synchroniser
	always_ff @(posedge i_sck or posedge i_rst)
	begin
		if (i_rst)
		begin
			opcode_hold <= 8'h00;
			cmd_toggle <= 1'b0;
		end
		else if (!i_cs_n && byte_done)
		begin
			opcode_hold <= {shift, i_mosi};
			cmd_toggle <= ~cmd_toggle;
		end
	end

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic above_meta, above_sync, min_meta, min_sync;
	// tog_last resets with cmd_toggle, so no false command follows a reset
	logic tog_meta, tog_sync, tog_last;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			above_meta <= 1'b0;
			above_sync <= 1'b0;
			min_meta <= 1'b0;
			min_sync <= 1'b0;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_last <= 1'b0;
		end
		else if (i_ce)
		begin
			above_meta <= i_above_lockout;
			above_sync <= above_meta;
			min_meta <= i_supply_at_min;
			min_sync <= min_meta;
			tog_meta <= cmd_toggle;
			tog_sync <= tog_meta;
			tog_last <= tog_sync;
		end
	end

	// ----------------------------------------------------------------
	// Internal power-on reset and delay counters
	// ----------------------------------------------------------------
	// Below lockout the counters and outputs are held as in reset, the synchronisers are not; the link side keeps
	// counting toggles so the edge detector stays aligned when supply returns
	wire logic_rst = i_rst || !above_sync;
	logic [CNT_W-1:0] wa_cnt;
	logic [CNT_W-1:0] settle_cnt;
	wire wa_done = (wa_cnt == CNT_W'(WRITE_ACCESS_CYCLES));
	wire settle_done = (settle_cnt == CNT_W'(SUPPLY_SETTLE_CYCLES));

	// Counters stop at their terminal count, so the gates never reopen by wrapping
	// Write-access delay starts when the supply crosses lockout
	always_ff @(posedge i_clk)
	begin
		if (logic_rst)
			wa_cnt <= '0;
		else if (i_ce && !wa_done)
			wa_cnt <= wa_cnt + CNT_W'(1);
	end

	// Settle delay restarts if the supply dips below its minimum
	always_ff @(posedge i_clk)
	begin
		if (logic_rst || !min_sync)
			settle_cnt <= '0;
		else if (i_ce && !settle_done)
			settle_cnt <= settle_cnt + CNT_W'(1);
	end

	// ----------------------------------------------------------------
	// Command classification
	// ----------------------------------------------------------------
	wire cmd_seen = (tog_sync != tog_last);
	wire [7:0] op = opcode_hold;
	wire is_write_class = (op == OP_WRITE_ENABLE) || (op == OP_PAGE_PROGRAM) ||
		(op == OP_QUAD_PAGE_PROGRAM) || (op == OP_QUAD_PROGRAM_SINGLE) ||
		(op == OP_DUAL_FAST_PROGRAM) || (op == OP_SECTOR_ERASE) ||
		(op == OP_HALF_BLOCK_ERASE) || (op == OP_BLOCK_ERASE) ||
		(op == OP_CHIP_ERASE) || (op == OP_SECURITY_REG_WRITE) ||
		(op == OP_STATUS_REG_WRITE);
	wire read_ok = settle_done;
	wire write_ok = wa_done && settle_done;
	wire admit = cmd_seen && (is_write_class ? write_ok : read_ok);
	wire refuse = cmd_seen && !admit;
	wire in_dpd = o_deep_power_down;
	// While in deep power-down only the release opcode is acted on
	wire act = admit && (!in_dpd || op == OP_RELEASE_POWER_DOWN);
	wire dpd_enter = act && (op == OP_DEEP_POWER_DOWN);
	wire next_dpd = act ? (op == OP_DEEP_POWER_DOWN ? 1'b1 :
		(op == OP_RELEASE_POWER_DOWN ? 1'b0 : in_dpd)) : in_dpd;
	wire next_wel = (act && op == OP_WRITE_ENABLE) ? 1'b1 :
		((act && op == OP_WRITE_DISABLE) ? 1'b0 : o_write_enable_latch);
	power_state_e next_power_state;

	assign next_power_state = write_ok ? PWR_FULL :
		(read_ok ? PWR_READ_ONLY : PWR_SETTLING);

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// Reset wins over i_ce; i_rst still clears the outputs during a freeze
	always_ff @(posedge i_clk)
	begin
		if (logic_rst)
		begin
			o_standby <= 1'b1;
			o_deep_power_down <= 1'b0;
			o_write_enable_latch <= 1'b0;
			o_read_ready <= 1'b0;
			o_write_ready <= 1'b0;
			o_cmd_valid <= 1'b0;
			o_cmd_refused <= 1'b0;
			o_cmd_opcode <= 8'h00;
			o_power_state <= PWR_LOCKED;
		end
		else if (i_ce)
		begin
			o_deep_power_down <= next_dpd;
			o_standby <= !next_dpd;
			o_write_enable_latch <= next_wel;
			o_read_ready <= read_ok;
			o_write_ready <= write_ok;
			o_cmd_valid <= act;
			o_cmd_refused <= refuse;
			if (cmd_seen)
				o_cmd_opcode <= op;
			o_power_state <= next_power_state;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_powerup_standby: assert property (@(posedge i_clk) disable iff (i_rst)
		logic_rst |=> (o_standby && !o_deep_power_down))
		else $error("not in standby after power-on reset");

	a_latch_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
		logic_rst |=> !o_write_enable_latch)
		else $error("write-enable latch survived power-on reset");

	a_latch_set_fresh: assert property (@(posedge i_clk) disable iff (i_rst)
		(!logic_rst && i_ce && act && op == OP_WRITE_ENABLE) |=> o_write_enable_latch)
		else $error("admitted write enable did not set the latch");

	a_lockout_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
		(logic_rst [*2]) |-> (!o_cmd_valid && !o_cmd_refused && !o_read_ready))
		else $error("command activity while below lockout");

	a_write_refused: assert property (@(posedge i_clk) disable iff (i_rst)
		(!logic_rst && i_ce && cmd_seen && is_write_class && !wa_done)
		|=> (o_cmd_refused && !o_cmd_valid))
		else $error("write-class command admitted before write-access delay");

	a_read_admitted: assert property (@(posedge i_clk) disable iff (i_rst)
		(!logic_rst && i_ce && cmd_seen && !is_write_class && settle_done && !in_dpd)
		|=> o_cmd_valid)
		else $error("read command refused after settle delay");

	a_settle_count: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_read_ready) |-> $past(settle_cnt) == CNT_W'(SUPPLY_SETTLE_CYCLES))
		else $error("read gate opened at wrong settle count");

	a_write_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		o_write_ready |-> (o_read_ready && wa_cnt == CNT_W'(WRITE_ACCESS_CYCLES)))
		else $error("write gate open before both delays ran");

	// Checks on what the host sees after a command or a supply change

	a_dpd_silent: assert property (@(posedge i_clk) disable iff (i_rst)
		(!logic_rst && i_ce && cmd_seen && in_dpd && op != OP_RELEASE_POWER_DOWN)
		|=> (!o_cmd_valid && o_deep_power_down))
		else $error("command acted on during deep power-down");

	a_dpd_by_cmd: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_deep_power_down) |-> $past(dpd_enter))
		else $error("deep power-down entered without a command");

	a_latch_needs_write: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_write_enable_latch) |-> o_write_ready)
		else $error("write-enable latch set while writes were gated");

	a_refuse_gate_shut: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cmd_refused |-> !o_write_ready)
		else $error("command refused with both delays done");

	a_valid_needs_read: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cmd_valid |-> o_read_ready)
		else $error("command admitted before settle delay");

	a_pulse_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
		!(o_cmd_valid && o_cmd_refused))
		else $error("command both admitted and refused");

	a_valid_single: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_cmd_valid && i_ce) |=> !o_cmd_valid)
		else $error("admit pulse longer than one cycle");

	a_settle_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		((!logic_rst && i_ce && !min_sync) ##1 i_ce) |=> !o_read_ready)
		else $error("read gate stayed open after supply dipped");

	a_lock_state: assert property (@(posedge i_clk) disable iff (i_rst)
		logic_rst |=> (o_power_state == PWR_LOCKED && !o_write_ready))
		else $error("state not locked below lockout");

	a_freeze_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(!i_ce && !logic_rst)
		|=> ($stable(o_read_ready) && $stable(o_write_enable_latch) && $stable(o_cmd_valid)))
		else $error("state moved while clock enable was low");

	c_read_early: cover property (@(posedge i_clk) disable iff (i_rst)
		o_cmd_valid && !o_write_ready);
	c_write_refused: cover property (@(posedge i_clk) disable iff (i_rst)
		o_cmd_refused && o_cmd_opcode == OP_PAGE_PROGRAM);
	c_wel_set: cover property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_write_enable_latch));
	c_deep_pd: cover property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_deep_power_down));
	c_supply_dip: cover property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_write_ready) && o_power_state == PWR_LOCKED);

endmodule : flash_power_gate

//--- core/flash_power_pkg.sv
/*
 Constants shared by the power-on command gate: opcode classes and the
 default delay counts. Assumes an SPI-style opcode byte, most significant bit first.
*/
package flash_power_pkg;

	// ----------------------------------------------------------------
	// Opcodes (one byte each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
	localparam logic [7:0] OP_QUAD_PROGRAM_SINGLE = 8'h32;
	localparam logic [7:0] OP_DUAL_FAST_PROGRAM = 8'hA2;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] OP_SECURITY_REG_WRITE = 8'h2F;
	localparam logic [7:0] OP_STATUS_REG_WRITE = 8'h01;
	localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_RELEASE_POWER_DOWN = 8'hAB;

	// ----------------------------------------------------------------
	// Delay counts in cycles of i_clk
	// ----------------------------------------------------------------
	localparam int WRITE_ACCESS_CYCLES_DEF = 1000;
	localparam int SUPPLY_SETTLE_CYCLES_DEF = 100;
	localparam int DELAY_CNT_W_DEF = 16;
	localparam int OPCODE_BITS = 8;

	typedef enum logic [1:0]
	{
		PWR_LOCKED,
		PWR_SETTLING,
		PWR_READ_ONLY,
		PWR_FULL
	} power_state_e;

endpackage : flash_power_pkg

//--- bench/flash_host_model.sv
/*
 Host controller model: frames one opcode per select, MSB first.
 Assumes the gate samples on the rising link clock edge, mode 0.
*/
`timescale 1ns/1ns
module flash_host_model
(
	// Link
	output logic o_sck,
	output logic o_cs_n,
	output logic o_mosi
);
	// Deselected and still until the bench calls send
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// Link clock runs only inside a frame, 30 ns period
	task automatic send(input logic [7:0] op);
		o_cs_n = 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			o_mosi = op[i];
			#15 o_sck = 1'b1;
			#15 o_sck = 1'b0;
		end
		#15 o_cs_n = 1'b1;
		// Released data line shows the inverse, never a stale bit
		o_mosi = ~o_mosi;
	endtask : send
endmodule : flash_host_model

//--- bench/flash_power_gate_tb.sv
/*
 Self-checking bench for the power-on command gate.
 Assumes short delay counts and a host model that is told when to send.
*/
`timescale 1ns/1ns
module flash_power_gate_tb;
	import flash_power_pkg::*;
	logic i_clk, i_rst, i_lo, i_min, ce, sck, cs_n, mosi;
	logic o_sb, o_dpd, o_wel, o_rr, o_wr, o_v, o_r;
	logic [7:0] o_op;
	power_state_e o_st;
	int error_cnt, n_checks, n_v, n_r;
	logic [7:0] wcls [11] = '{OP_WRITE_ENABLE, OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM,
		OP_QUAD_PROGRAM_SINGLE, OP_DUAL_FAST_PROGRAM, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE,
		OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_SECURITY_REG_WRITE, OP_STATUS_REG_WRITE};

	flash_power_gate #(.WRITE_ACCESS_CYCLES(400), .SUPPLY_SETTLE_CYCLES(8)) u_flash_power_gate
	(
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_above_lockout(i_lo),
		.i_supply_at_min(i_min), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
		.o_standby(o_sb), .o_deep_power_down(o_dpd), .o_write_enable_latch(o_wel),
		.o_read_ready(o_rr), .o_write_ready(o_wr), .o_cmd_valid(o_v),
		.o_cmd_refused(o_r), .o_cmd_opcode(o_op), .o_power_state(o_st)
	);
	flash_host_model u_flash_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));

	// ----------------------------------------------------------------
	// Clock, pulse counting and checks
	// ----------------------------------------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		n_v += (o_v === 1'b1);
		n_r += (o_r === 1'b1);
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// Pulses land on the third clock edge after the last link edge; 12 gives slack
	task automatic cmd(input logic [7:0] op, input int ev, input int er);
		int v0;
		int r0;
		v0 = n_v;
		r0 = n_r;
		u_flash_host_model.send(op);
		repeat (12) @(posedge i_clk);
		chk("valid count", 8'(ev), 8'(n_v - v0));
		chk("refused count", 8'(er), 8'(n_r - r0));
		if (ev + er > 0)
			chk("opcode", op, o_op);
	endtask : cmd

	task automatic wait_hi(input bit rd, input int lim);
		int n;
		for (n = 0; n < lim && (rd ? o_rr : o_wr) !== 1'b1; n++)
			@(posedge i_clk);
		if (n == lim)
		begin
			error_cnt++;
			$display("unexpected ready wait: expected 1, seen timeout");
			end_of_test();
		end
	endtask : wait_hi

	task automatic t_locked();
		chk("standby", 8'h01, o_sb);
		chk("deep pd", 8'h00, o_dpd);
		chk("latch", 8'h00, o_wel);
		chk("state", PWR_LOCKED, o_st);
		cmd(8'h03, 0, 0);
		$display("locked done");
	endtask : t_locked

	task automatic t_read_window();
		@(posedge i_clk) i_lo <= 1'b1;
		repeat (6) @(posedge i_clk);
		chk("read ready early", 8'h00, o_rr);
		@(posedge i_clk) i_min <= 1'b1;
		wait_hi(1'b1, 40);
		chk("write ready", 8'h00, o_wr);
		cmd(8'h03, 1, 0);
		foreach (wcls[i])
			cmd(wcls[i], 0, 1);
		cmd(OP_WRITE_DISABLE, 1, 0);
		chk("latch", 8'h00, o_wel);
		$display("read window done");
	endtask : t_read_window

	task automatic t_full();
		wait_hi(1'b0, 500);
		chk("state", PWR_FULL, o_st);
		cmd(8'h06, 1, 0);
		chk("latch set", 8'h01, o_wel);
		cmd(8'hB9, 1, 0);
		chk("standby", 8'h00, o_sb);
		cmd(8'h03, 0, 0);
		cmd(8'hAB, 1, 0);
		chk("deep pd", 8'h00, o_dpd);
		$display("full access done");
	endtask : t_full

	task automatic t_freeze();
		int v0;
		v0 = n_v;
		@(posedge i_clk) ce <= 1'b0;
		@(posedge i_clk);
		u_flash_host_model.send(OP_WRITE_DISABLE);
		repeat (12) @(posedge i_clk);
		chk("frozen valid count", 8'h00, 8'(n_v - v0));
		chk("frozen latch", 8'h01, o_wel);
		@(posedge i_clk) ce <= 1'b1;
		repeat (8) @(posedge i_clk);
		chk("valid count", 8'h01, 8'(n_v - v0));
		chk("latch cleared", 8'h00, o_wel);
		chk("opcode", OP_WRITE_DISABLE, o_op);
		@(posedge i_clk) i_min <= 1'b0;
		repeat (6) @(posedge i_clk);
		chk("state", PWR_SETTLING, o_st);
		chk("write ready", 8'h00, o_wr);
		@(posedge i_clk) i_min <= 1'b1;
		wait_hi(1'b1, 40);
		wait_hi(1'b0, 40);
		cmd(OP_WRITE_ENABLE, 1, 0);
		chk("latch set", 8'h01, o_wel);
		$display("freeze and settle restart done");
	endtask : t_freeze

	task automatic t_brownout();
		@(posedge i_clk) i_lo <= 1'b0;
		repeat (5) @(posedge i_clk);
		chk("latch", 8'h00, o_wel);
		chk("read ready", 8'h00, o_rr);
		chk("state", PWR_LOCKED, o_st);
		cmd(8'h06, 0, 0);
		$display("brownout done");
	endtask : t_brownout

	initial
	begin
		error_cnt = 0;
		n_checks = 0;
		n_v = 0;
		n_r = 0;
		i_rst = 1'b1;
		i_lo = 1'b0;
		i_min = 1'b0;
		ce = 1'b1;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
		t_locked();
		t_read_window();
		t_full();
		t_freeze();
		t_brownout();
		end_of_test();
	end
endmodule : flash_power_gate_tb
